/* include/sbcst_pkg.sv */
// Purpose: Shared constants and types of the serial status responder.
// Assumes: One 100 MHz clock; serial pins already synchronous to it.
// Notes: Sub-address codes and the flag source order are local choices.
package sbcst_pkg;

  // ----------------------------------------------------------------
  // Frame and command layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;
  localparam logic [4:0] BITCNT_ZERO = 5'h00;
  localparam logic [4:0] BITCNT_ONE = 5'h01;
  localparam logic [4:0] BITCNT_MAX = 5'h1F;
  localparam logic [4:0] BITCNT_LOW_LOAD = 5'h08;
  localparam logic [4:0] BITCNT_FRAME = 5'h10;
  localparam logic [1:0] CMD_READ_A = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ_B = 2'h3;
  localparam int unsigned CMD_TYPE_HI = 7;
  localparam int unsigned CMD_TYPE_LO = 6;
  localparam int unsigned CMD_ADDR_HI = 5;
  localparam int unsigned CMD_ADDR_LO = 1;

  // Flag sub-addresses, carried in command bits 13..9
  localparam logic [4:0] ADDR_REGULATOR = 5'h0A;
  localparam logic [4:0] ADDR_CAN = 5'h0B;
  localparam logic [4:0] ADDR_IO = 5'h0C;
  localparam logic [4:0] ADDR_SAFE = 5'h0D;

  // ----------------------------------------------------------------
  // Flag sources, one flag group per sub-address half, one for the safe sub-address
  // ----------------------------------------------------------------
  localparam int unsigned SRC_COUNT = 7;
  localparam int unsigned FLAG_W = 8;
  localparam logic [2:0] SRC_CAN_LOCAL = 3'h0;
  localparam logic [2:0] SRC_CAN_BUS = 3'h1;
  localparam logic [2:0] SRC_IO_LOW = 3'h2;
  localparam logic [2:0] SRC_IO_HIGH = 3'h3;
  localparam logic [2:0] SRC_SAFE = 3'h4;
  localparam logic [2:0] SRC_REG_LOW = 3'h5;
  localparam logic [2:0] SRC_REG_HIGH = 3'h6;
  localparam logic [7:0] FLAGS_CLEAR = 8'h00;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_INT = 15;
  localparam int unsigned ST_WAKE = 14;
  localparam int unsigned ST_RESET = 13;
  localparam int unsigned ST_CAN_GROUP = 12;
  localparam int unsigned ST_IO_GROUP = 10;
  localparam int unsigned ST_SAFE_GROUP = 9;
  localparam int unsigned ST_REG_GROUP = 8;
  localparam int unsigned ST_CAN_BUS = 7;
  localparam int unsigned ST_CAN_LOCAL = 6;
  localparam int unsigned ST_IO_LOW = 3;
  localparam int unsigned ST_IO_HIGH = 2;
  localparam int unsigned ST_REG_HIGH = 1;
  localparam int unsigned ST_REG_LOW = 0;
  localparam logic [15:0] STATUS_CLEAR = 16'h0000;

  typedef enum logic [1:0] {
    SBCST_IDLE = 2'h0,
    SBCST_SHIFT = 2'h1,
    SBCST_DONE = 2'h3
  } sbcst_phase_t;

  typedef struct packed {
    sbcst_phase_t phase;
    logic sclkPrev;
    logic [4:0] bitCnt;
    logic [15:0] rxShift;
    logic [15:0] txShift;
    logic [15:0] snapshot;
    logic [1:0] cmdType;
    logic [2:0] selSrc;
    logic selValid;
    logic [SRC_COUNT-1:0] clearVec;
    logic miso;
    logic misoOe;
    logic [15:0] statusWord;
  } sbcst_resp_state_t;

  typedef struct packed {
    logic [FLAG_W-1:0] intFlags;
    logic [FLAG_W-1:0] wakeFlags;
    logic [FLAG_W-1:0] resetFlags;
  } sbcst_flag_state_t;

endpackage : sbcst_pkg

/* design/sbcst_flag_group.sv */
// Purpose: Sticky interrupt, wake-up and reset flags of one flag source (one sub-address half, or the safe sub-address).
// Assumes: Event inputs are one-cycle or level requests on clk.
// Notes: A new event in the clearing cycle survives the clear.
`timescale 1ns/1ps
module sbcst_flag_group (
  input wire logic clk,
  input wire logic srst,
  input wire logic [sbcst_pkg::FLAG_W-1:0] intSet,
  input wire logic [sbcst_pkg::FLAG_W-1:0] wakeSet,
  input wire logic [sbcst_pkg::FLAG_W-1:0] resetSet,
  input wire logic clearReq,
  output logic [sbcst_pkg::FLAG_W-1:0] intFlags,
  output logic [sbcst_pkg::FLAG_W-1:0] wakeFlags,
  output logic [sbcst_pkg::FLAG_W-1:0] resetFlags
);
  import sbcst_pkg::*;

  sbcst_flag_state_t st;
  sbcst_flag_state_t next_st;
  logic [FLAG_W-1:0] keepMask;

  // ----------------------------------------------------------------
  // Flag update
  // ----------------------------------------------------------------
  always_comb begin
    keepMask = clearReq ? FLAGS_CLEAR : ~FLAGS_CLEAR;
    // RULE_16 set until read
    next_st.intFlags = (st.intFlags & keepMask) | intSet;
    next_st.wakeFlags = (st.wakeFlags & keepMask) | wakeSet;
    next_st.resetFlags = (st.resetFlags & keepMask) | resetSet;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '{intFlags: FLAGS_CLEAR, wakeFlags: FLAGS_CLEAR, resetFlags: FLAGS_CLEAR};
    end else begin
      st <= next_st;
    end
  end

  assign intFlags = st.intFlags;
  assign wakeFlags = st.wakeFlags;
  assign resetFlags = st.resetFlags;

endmodule : sbcst_flag_group

/* design/sbcst_status_resp.sv */
// Purpose: Serial status responder; shifts the fixed status byte on MISO, then the extended status byte on writes or the addressed flag byte on reads.
// Assumes: sclk, csN and mosi are synchronous to clk and slower than clk/2.
// Notes: MOSI sampled and MISO updated on sclk rise; host samples MISO on fall.
// Function
// RULE_01: Read command types 00 or 11 return only the fixed status byte first; code then shifts the addressed flag byte.
// RULE_02: Write command type 01 returns fixed status then extended status.
// RULE_03: Bit 15 high while any interrupt flag is still unread.
// RULE_04: Bit 14 high while any wake-up flag is still unread.
// RULE_05: Bit 13 high while any reset cause flag is still unread.
// RULE_06: Bit 12 high when a pending cause is CAN, local or bus.
// RULE_07: Bit 10 high when a pending cause is an input/output interface.
// RULE_08: Bit 9 high when a pending cause is a safe-state condition.
// RULE_09: Bit 8 high when a pending cause is a regulator or voltage monitor.
// RULE_10: Bit 7 high when a pending cause is the CAN bus side.
// RULE_11: Bit 6 high when a pending cause is the CAN local side.
// RULE_12: Bit 3 flags pending input/output event at low sub-address.
// RULE_13: Bit 2 flags pending input/output event at high sub-address.
// RULE_14: Bit 1 flags pending regulator event at high sub-address.
// RULE_15: Bit 0 flags pending regulator event at low sub-address.
// RULE_16: Each flag sets on its event and clears only after a host read.
// RULE_17: Shifting status never clears it; summaries follow underlying flags.
// RULE_18: Host treats status as read-only and reads flag sub-address to clear.
`timescale 1ns/1ps
module sbcst_status_resp (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic [sbcst_pkg::SRC_COUNT*sbcst_pkg::FLAG_W-1:0] intEvent,
  input wire logic [sbcst_pkg::SRC_COUNT*sbcst_pkg::FLAG_W-1:0] wakeEvent,
  input wire logic [sbcst_pkg::SRC_COUNT*sbcst_pkg::FLAG_W-1:0] resetEvent,
  output logic miso,
  output logic misoOe,
  output logic [15:0] statusWord
);
  import sbcst_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Maps a sub-address and its half select to a flag source
  function automatic logic [3:0] decodeSource(input logic [4:0] addr, input logic half);
    logic [3:0] res;
    res = {1'b0, SRC_CAN_LOCAL};
    unique case (addr)
      ADDR_CAN: res = {1'b1, half ? SRC_CAN_BUS : SRC_CAN_LOCAL};
      ADDR_IO: res = {1'b1, half ? SRC_IO_HIGH : SRC_IO_LOW};
      ADDR_SAFE: res = {1'b1, SRC_SAFE};
      ADDR_REGULATOR: res = {1'b1, half ? SRC_REG_HIGH : SRC_REG_LOW};
      default: res = {1'b0, SRC_CAN_LOCAL};
    endcase
    return res;
  endfunction : decodeSource

  function automatic logic isRead(input logic [1:0] cmdType);
    return (cmdType == CMD_READ_A) || (cmdType == CMD_READ_B);
  endfunction : isRead

  // ----------------------------------------------------------------
  // Flag groups
  // ----------------------------------------------------------------
  sbcst_resp_state_t st;
  sbcst_resp_state_t next_st;
  logic [FLAG_W-1:0] intFlags [SRC_COUNT];
  logic [FLAG_W-1:0] wakeFlags [SRC_COUNT];
  logic [FLAG_W-1:0] resetFlags [SRC_COUNT];
  logic [FLAG_W-1:0] srcByte [SRC_COUNT];
  logic [SRC_COUNT-1:0] srcPending;
  logic anyInt;
  logic anyWake;
  logic anyReset;
  logic [15:0] liveStatus;
  logic sclkRise;
  logic [3:0] srcDecode;
  logic [1:0] newType;
  logic [7:0] lowByte;

  for (genvar g = 0; g < SRC_COUNT; g++) begin : gFlags
    sbcst_flag_group uGroup (
      .clk(clk),
      .srst(srst),
      .intSet(intEvent[g*FLAG_W +: FLAG_W]),
      .wakeSet(wakeEvent[g*FLAG_W +: FLAG_W]),
      .resetSet(resetEvent[g*FLAG_W +: FLAG_W]),
      .clearReq(st.clearVec[g]),
      .intFlags(intFlags[g]),
      .wakeFlags(wakeFlags[g]),
      .resetFlags(resetFlags[g])
    );
  end

  // ----------------------------------------------------------------
  // Status summary
  // ----------------------------------------------------------------
  always_comb begin
    anyInt = 1'b0;
    anyWake = 1'b0;
    anyReset = 1'b0;
    for (int i = 0; i < SRC_COUNT; i++) begin
      srcByte[i] = intFlags[i] | wakeFlags[i] | resetFlags[i];
      // RULE_17 summary from flags
      srcPending[i] = |srcByte[i];
      anyInt = anyInt | (|intFlags[i]);
      anyWake = anyWake | (|wakeFlags[i]);
      anyReset = anyReset | (|resetFlags[i]);
    end
    liveStatus = STATUS_CLEAR;
    // RULE_03 interrupt pending
    liveStatus[ST_INT] = anyInt;
    // RULE_04 wake-up pending
    liveStatus[ST_WAKE] = anyWake;
    // RULE_05 reset pending
    liveStatus[ST_RESET] = anyReset;
    // RULE_06 CAN group
    liveStatus[ST_CAN_GROUP] = srcPending[SRC_CAN_LOCAL] | srcPending[SRC_CAN_BUS];
    // RULE_07 input/output group
    liveStatus[ST_IO_GROUP] = srcPending[SRC_IO_LOW] | srcPending[SRC_IO_HIGH];
    // RULE_08 safe group
    liveStatus[ST_SAFE_GROUP] = srcPending[SRC_SAFE];
    // RULE_09 regulator group
    liveStatus[ST_REG_GROUP] = srcPending[SRC_REG_LOW] | srcPending[SRC_REG_HIGH];
    // RULE_10 CAN bus side
    liveStatus[ST_CAN_BUS] = srcPending[SRC_CAN_BUS];
    // RULE_11 CAN local side
    liveStatus[ST_CAN_LOCAL] = srcPending[SRC_CAN_LOCAL];
    // RULE_12 input/output low
    liveStatus[ST_IO_LOW] = srcPending[SRC_IO_LOW];
    // RULE_13 input/output high
    liveStatus[ST_IO_HIGH] = srcPending[SRC_IO_HIGH];
    // RULE_14 regulator high
    liveStatus[ST_REG_HIGH] = srcPending[SRC_REG_HIGH];
    // RULE_15 regulator low
    liveStatus[ST_REG_LOW] = srcPending[SRC_REG_LOW];
  end

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.sclkPrev = sclk;
    next_st.clearVec = '0;
    next_st.statusWord = liveStatus;
    sclkRise = sclk & ~st.sclkPrev;
    newType = st.rxShift[CMD_TYPE_HI:CMD_TYPE_LO];
    srcDecode = decodeSource(st.rxShift[CMD_ADDR_HI:CMD_ADDR_LO], mosi);
    lowByte = 8'h00;
    // RULE_02 write returns extended byte
    if (newType == CMD_WRITE) begin
      lowByte = st.snapshot[7:0];
    end else if (isRead(newType) && srcDecode[3]) begin
      // RULE_01 read returns fixed byte then addressed flag byte
      lowByte = srcByte[srcDecode[2:0]];
    end
    unique case (st.phase)
      SBCST_IDLE: begin
        next_st.misoOe = 1'b0;
        if (!csN) begin
          // RULE_17 snapshot only, no clear
          next_st.phase = SBCST_SHIFT;
          next_st.bitCnt = BITCNT_ZERO;
          next_st.snapshot = st.statusWord;
          next_st.txShift = st.statusWord;
          next_st.miso = st.statusWord[ST_INT];
          next_st.misoOe = 1'b1;
          next_st.selValid = 1'b0;
          next_st.cmdType = CMD_READ_A;
        end
      end
      SBCST_SHIFT: begin
        if (csN) begin
          next_st.phase = SBCST_DONE;
          next_st.misoOe = 1'b0;
        end else if (sclkRise) begin
          next_st.rxShift = {st.rxShift[14:0], mosi};
          if (st.bitCnt != BITCNT_MAX) begin
            next_st.bitCnt = st.bitCnt + BITCNT_ONE;
          end
          if (st.bitCnt == BITCNT_LOW_LOAD) begin
            next_st.cmdType = newType;
            next_st.selSrc = srcDecode[2:0];
            next_st.selValid = srcDecode[3];
            next_st.txShift = {lowByte, 8'h00};
            next_st.miso = lowByte[7];
          end else if (st.bitCnt != BITCNT_ZERO) begin
            next_st.txShift = {st.txShift[14:0], 1'b0};
            next_st.miso = st.txShift[14];
          end
        end
      end
      SBCST_DONE: begin
        next_st.phase = SBCST_IDLE;
        next_st.misoOe = 1'b0;
        // RULE_16 clear after complete read
        // RULE_18 sub-address read clears
        if ((st.bitCnt == BITCNT_FRAME) && isRead(st.cmdType) && st.selValid) begin
          next_st.clearVec[st.selSrc] = 1'b1;
        end
      end
      default: begin
        next_st.phase = SBCST_IDLE;
        next_st.misoOe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '{
        phase: SBCST_IDLE,
        sclkPrev: 1'b0,
        bitCnt: BITCNT_ZERO,
        rxShift: STATUS_CLEAR,
        txShift: STATUS_CLEAR,
        snapshot: STATUS_CLEAR,
        cmdType: CMD_READ_A,
        selSrc: SRC_CAN_LOCAL,
        selValid: 1'b0,
        clearVec: '0,
        miso: 1'b0,
        misoOe: 1'b0,
        statusWord: STATUS_CLEAR
      };
    end else begin
      st <= next_st;
    end
  end

  assign miso = st.miso;
  assign misoOe = st.misoOe;
  assign statusWord = st.statusWord;

endmodule : sbcst_status_resp

/* bench/sbcst_resp_sva.sv */
// Purpose: Port-level checks of the serial status responder.
// Assumes: Bound to sbcst_status_resp; one clock domain.
// Notes: Summary bits are checked against group bits each cycle.
`timescale 1ns/1ps
module sbcst_resp_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic csN,
  input wire logic [sbcst_pkg::SRC_COUNT*sbcst_pkg::FLAG_W-1:0] intEvent,
  input wire logic [sbcst_pkg::SRC_COUNT*sbcst_pkg::FLAG_W-1:0] resetEvent,
  input wire logic miso,
  input wire logic misoOe,
  input wire logic [15:0] statusWord
);
  import sbcst_pkg::*;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_int_set; |intEvent |-> ##2 statusWord[ST_INT]; endproperty
  a_int_set: assert property (p_int_set)
    else $error("interrupt summary missing");
  property p_rst_set; |resetEvent |-> ##2 statusWord[ST_RESET]; endproperty
  a_rst_set: assert property (p_rst_set)
    else $error("reset summary missing");
  property p_can_grp; statusWord[12] == (statusWord[7] | statusWord[6]); endproperty
  a_can_grp: assert property (p_can_grp)
    else $error("CAN group mismatch");
  property p_io_grp; statusWord[10] == (statusWord[3] | statusWord[2]); endproperty
  a_io_grp: assert property (p_io_grp)
    else $error("io group mismatch");
  property p_reg_grp; statusWord[8] == (statusWord[1] | statusWord[0]); endproperty
  a_reg_grp: assert property (p_reg_grp)
    else $error("regulator group mismatch");
  property p_grp_any;
    (|statusWord[15:13]) == (|{statusWord[12], statusWord[10:8]});
  endproperty
  a_grp_any: assert property (p_grp_any)
    else $error("summary without group");
  // A clear issued just before a new frame may still land in the frame's first cycles
  property p_hold;
    !csN && misoOe && $past(misoOe) && statusWord[ST_INT] |=> statusWord[ST_INT];
  endproperty
  a_hold: assert property (p_hold)
    else $error("summary dropped in frame");
  property p_start;
    $fell(csN) && !misoOe |=> misoOe && miso == $past(statusWord[ST_INT]);
  endproperty
  a_start: assert property (p_start)
    else $error("frame start bit wrong");
  c_start: cover property ($fell(csN) && !misoOe);
  c_int: cover property (|intEvent);
  c_drop: cover property ($fell(statusWord[ST_INT]));
endmodule : sbcst_resp_sva

/* bench/sbcst_host.sv */
// Purpose: Serial host model issuing one 16-bit command per frame.
// Assumes: Driven on falling clk edges; sclk phases of several clks.
// Notes: MOSI shows the inverse of its last bit outside frames.
`timescale 1ns/1ps
module sbcst_host (
  input wire logic clk,
  input wire logic miso,
  output logic csN,
  output logic sclk,
  output logic mosi,
  output logic [15:0] resp,
  output logic respDone
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    resp = 16'h0000;
    respDone = 1'b0;
  end
  task automatic xfer(input logic [15:0] cmd);
    int i;
    @(negedge clk) csN = 1'b0;
    repeat (2) @(negedge clk);
    for (i = 15; i >= 0; i--) begin
      mosi = cmd[i];
      @(negedge clk) sclk = 1'b1;
      repeat (3) @(negedge clk);
      resp[i] = miso;
      sclk = 1'b0;
      repeat (2) @(negedge clk);
    end
    csN = 1'b1;
    mosi = ~mosi;
    respDone = 1'b1;
    @(negedge clk) respDone = 1'b0;
    repeat (4) @(negedge clk);
  endtask : xfer
endmodule : sbcst_host

/* bench/test_spi_status_response.sv */
// Purpose: Random flag traffic and status frames against a flag model.
// Assumes: Events and frames never overlap in time.
// Notes: Responses are queued by the driver and compared on arrival.
`timescale 1ns/1ps
module test_spi_status_response;
  import sbcst_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [SRC_COUNT*FLAG_W-1:0] intEvent = '0;
  logic [SRC_COUNT*FLAG_W-1:0] wakeEvent = '0;
  logic [SRC_COUNT*FLAG_W-1:0] resetEvent = '0;
  logic [SRC_COUNT*FLAG_W-1:0] ev;
  logic miso, misoOe, csN, sclk, mosi, respDone;
  logic [15:0] statusWord, resp, st;
  logic [7:0] fl [3][7];
  logic [15:0] expQ [$];
  logic [31:0] rs = 32'h0000_0003;
  logic [1:0] ty;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n, s, k;
  always #5 clk = ~clk;
  sbcst_status_resp uut (.clk(clk), .srst(srst), .sclk(sclk), .csN(csN), .mosi(mosi),
    .intEvent(intEvent), .wakeEvent(wakeEvent), .resetEvent(resetEvent),
    .miso(miso), .misoOe(misoOe), .statusWord(statusWord));
  sbcst_host host (.clk(clk), .miso(miso), .csN(csN), .sclk(sclk), .mosi(mosi),
    .resp(resp), .respDone(respDone));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic void xorshift();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
  endfunction : xorshift
  function automatic logic [7:0] srcOr(int i);
    return fl[0][i] | fl[1][i] | fl[2][i];
  endfunction : srcOr
  function automatic logic [15:0] expStatus();
    logic [15:0] w;
    logic [6:0] p;
    w = 16'h0000;
    for (int i = 0; i < 7; i++) begin
      p[i] = |srcOr(i);
      w[15:13] = w[15:13] | {|fl[0][i], |fl[1][i], |fl[2][i]};
    end
    w[12] = p[0] | p[1];
    w[10] = p[2] | p[3];
    w[9:6] = {p[4], p[5] | p[6], p[1], p[0]};
    w[3:0] = {p[2], p[3], p[6], p[5]};
    return w;
  endfunction : expStatus
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string name);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic resetRun();
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    foreach (fl[i, j]) fl[i][j] = 8'h00;
    check(statusWord, 16'h0000, "statusWord");
    check({14'h0000, miso, misoOe}, 16'h0000, "misoOe");
  endtask : resetRun
  // ----------------------------------------------------------------
  // Response observer and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (respDone === 1'b1) check(resp, expQ.pop_front(), "resp");
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetRun();
    for (n = 0; n < 30; n++) begin
      xorshift();
      s = rs[7:0] % 7;
      k = rs[15:8] % 3;
      ev = '0;
      ev[8 * s + rs[18:16]] = 1'b1;
      intEvent = k == 0 ? ev : '0;
      wakeEvent = k == 1 ? ev : '0;
      resetEvent = k == 2 ? ev : '0;
      fl[k][s][rs[18:16]] = 1'b1;
      @(negedge clk);
      intEvent = '0;
      wakeEvent = '0;
      resetEvent = '0;
      repeat (3) @(negedge clk);
      check(statusWord, expStatus(), "statusWord");
      if (rs[20]) begin
        ty = rs[9:8] == 2'h2 ? CMD_READ_B : rs[9:8];
        st = expStatus();
        expQ.push_back({st[15:8], ty == CMD_WRITE ? st[7:0] : srcOr(s)});
        host.xfer({ty, s < 2 ? ADDR_CAN : s < 4 ? ADDR_IO : s == 4 ? ADDR_SAFE : ADDR_REGULATOR,
          1'b0, s == 1 || s == 3 || s == 6, 7'h00});
        if (ty != CMD_WRITE) foreach (fl[i]) fl[i][s] = 8'h00;
        repeat (2) @(negedge clk);
        check(statusWord, expStatus(), "cleared");
      end
    end
    st = expStatus();
    expQ.push_back({st[15:8], 8'h00});
    host.xfer({CMD_READ_A, 5'h1F, 9'h000});
    repeat (2) @(negedge clk);
    check(statusWord, st, "unmapped");
    // Command type 10: fixed byte then zeros, nothing cleared
    expQ.push_back({st[15:8], 8'h00});
    host.xfer({2'h2, ADDR_IO, 9'h080});
    repeat (2) @(negedge clk);
    check(statusWord, st, "type10");
    resetRun();
    print_verdict();
  end
endmodule : test_spi_status_response
bind sbcst_status_resp sbcst_resp_sva chk (.clk(clk), .srst(srst), .csN(csN),
  .intEvent(intEvent), .resetEvent(resetEvent), .miso(miso), .misoOe(misoOe),
  .statusWord(statusWord));
